// ---- core/flash_guard.sv ----
// Program flash read limit partitioning plus write/erase timing control.
// Assumes the core presents fetch PC, access address and op strobes on SYS_CLK.
`timescale 1ns/10ps
`default_nettype none

// Contract
// (RL1) Code reads from upper partition into lower partition return zero.
// (RL2) Lower partition code reads and writes everywhere freely.
// (RL3) Upper partition code may still fetch and execute lower partition code.
// (RL4) Boundary is limit byte times 256.
// (RL5) Reset limit zero gives boundary zero: all readable.
// (RL6) Software should keep the boundary on 512-byte multiples.
// (RL7) Protected firmware lives low, runs from reset vector first.
// (RL8) After reset execution starts at the reset vector.
// (RL9) Prescaler is smallest code whose range holds the system clock.
// (RL10) Prescaler all ones refuses every write and erase.
// (RL11) Upper code cannot read, write or erase below the boundary.
// (RL12) Core stalls for the whole timed write or erase.
// (RL13) Limit register takes only the first write after reset.
// (RL14) Timing register keeps top two bits, zero unused, reserved codes invalid.
module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int ERASE_CYCLE_COUNT = ERASE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic [15:0] FETCH_PC,
  input wire logic [15:0] MEM_ADDR,
  input wire logic CODE_READ,
  input wire logic FLASH_WRITE,
  input wire logic FLASH_ERASE,
  input wire logic [7:0] FLASH_RDATA,
  output logic [7:0] CODE_RDATA,
  output logic FLASH_PROG_START,
  output logic FLASH_PROG_IS_ERASE,
  output logic ACCESS_DENIED,
  output logic CORE_STALL,
  output logic [15:0] RESET_PC,
  output logic PRESCALE_VALID
);
  // The busy counter is 18 bits wide, which bounds the erase count
  if (ERASE_CYCLE_COUNT < 1 || ERASE_CYCLE_COUNT > 200_000) begin : gen_erase_count_check
    $error("ERASE_CYCLE_COUNT out of range");
  end

  logic [7:0] read_limit_reg;
  logic limit_locked_reg;
  logic [7:0] timing_reg;
  logic [17:0] busy_count_reg;
  logic [15:0] boundary;
  logic pc_upper;
  logic addr_lower;
  logic blocked;
  logic prescale_ok;

  // Boundary moves in 256-byte steps; sector alignment is left to software
  assign boundary = {read_limit_reg, 8'h00}; // [RL4] [RL5]
  assign pc_upper = (FETCH_PC >= boundary);
  assign addr_lower = (MEM_ADDR < boundary);
  // Only data-style accesses are judged here; instruction fetch never passes this path [RL3]
  assign blocked = pc_upper && addr_lower; // [RL2] [RL11]
  assign prescale_ok = (timing_reg[3:0] <= PRESCALE_MAX_VALID); // [RL14]

  // One-shot lock: upper code cannot move the boundary once startup code has set it
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      read_limit_reg <= READ_LIMIT_RESET;
      limit_locked_reg <= 1'b0;
    end else if (SFR_WR && SFR_ADDR == READ_LIMIT_ADDR && !limit_locked_reg) begin
      read_limit_reg <= SFR_WDATA; // [RL13]
      limit_locked_reg <= 1'b1;
    end
  end

  // Software picks the code for its clock; hardware only refuses bad codes [RL9]
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      timing_reg <= TIMING_CTRL_RESET;
    end else if (SFR_WR && SFR_ADDR == TIMING_CTRL_ADDR) begin
      timing_reg <= {SFR_WDATA[ONESHOT_BIT], SFR_WDATA[READ_ALWAYS_BIT], 2'b00,
                     SFR_WDATA[3:0]}; // [RL14]
    end
  end

  // Read data is registered, so it shows the register one edge after the address
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_ADDR == TIMING_CTRL_ADDR) begin
      SFR_RDATA <= timing_reg;
    end else if (SFR_ADDR == READ_LIMIT_ADDR) begin
      SFR_RDATA <= read_limit_reg;
    end else begin
      SFR_RDATA <= 8'h00;
    end
  end

  // Zeros stand in for protected bytes; the result holds until the next code read
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      CODE_RDATA <= 8'h00;
    end else if (CODE_READ) begin
      CODE_RDATA <= blocked ? BLOCKED_READ_VALUE : FLASH_RDATA; // [RL1]
    end
  end

  // Requests that arrive during a stall are dropped rather than queued
  logic start_ok;
  assign start_ok = (FLASH_WRITE || FLASH_ERASE) && !blocked && prescale_ok &&
                    busy_count_reg == 18'd0; // [RL10] [RL11]

  // The busy count runs down to one; the stall drops on the edge after that
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      busy_count_reg <= 18'd0;
      FLASH_PROG_START <= 1'b0;
      FLASH_PROG_IS_ERASE <= 1'b0;
      CORE_STALL <= 1'b0;
    end else begin
      FLASH_PROG_START <= start_ok;
      if (start_ok) begin
        FLASH_PROG_IS_ERASE <= FLASH_ERASE;
        busy_count_reg <= FLASH_ERASE ? 18'(ERASE_CYCLE_COUNT) : 18'(WRITE_CYCLES);
        CORE_STALL <= 1'b1; // [RL12]
      end else if (busy_count_reg > 18'd1) begin
        busy_count_reg <= busy_count_reg - 18'd1;
      end else begin
        busy_count_reg <= 18'd0;
        CORE_STALL <= 1'b0;
      end
    end
  end

  // Reset vector is fixed, so protected startup code always runs before upper code
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ACCESS_DENIED <= 1'b0;
      PRESCALE_VALID <= 1'b0;
      RESET_PC <= RESET_VECTOR; // [RL8] [RL7]
    end else begin
      ACCESS_DENIED <= (CODE_READ || FLASH_WRITE || FLASH_ERASE) && blocked;
      PRESCALE_VALID <= prescale_ok;
      RESET_PC <= RESET_VECTOR;
    end
  end

  // Checks on what this block drives; nothing is assumed of the core
  chk_blocked_read_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL1]
    CODE_READ && blocked |=> CODE_RDATA == 8'h00)
    else $error("blocked code read returned nonzero");
  chk_lower_read_open: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL2]
    CODE_READ && FETCH_PC < boundary |=> CODE_RDATA == $past(FLASH_RDATA))
    else $error("lower partition read was altered");
  chk_limit_once: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL13]
    limit_locked_reg |=> $stable(read_limit_reg))
    else $error("limit changed after first write");
  chk_disabled_no_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL10]
    timing_reg[3:0] == 4'hf |=> !FLASH_PROG_START)
    else $error("program started with prescaler disabled");
  chk_upper_no_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL11]
    (FLASH_WRITE || FLASH_ERASE) && blocked |=> !FLASH_PROG_START && ACCESS_DENIED)
    else $error("protected flash write not refused");
  chk_stall_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL12]
    start_ok && !FLASH_ERASE |=> CORE_STALL [*8])
    else $error("stall ended early during write");
  chk_unused_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL14]
    timing_reg[5:4] == 2'b00)
    else $error("unused timing bits not zero");
  chk_reset_limit: assert property (@(posedge SYS_CLK) // [RL5]
    $past(SYS_RST) |-> boundary == 16'h0000)
    else $error("boundary not zero after reset");

  // Helper for the stall checks: length of the current stall and the length it should have
  // It counts every stalled edge on its own, so a slip in the busy count shows up
  logic [17:0] stall_run_reg;
  logic [17:0] stall_want_reg;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      stall_run_reg <= 18'd0;
      stall_want_reg <= 18'd0;
    end else if (start_ok) begin
      stall_run_reg <= 18'd1;
      stall_want_reg <= FLASH_ERASE ? 18'(ERASE_CYCLE_COUNT) : 18'(WRITE_CYCLES);
    end else if (CORE_STALL) begin
      stall_run_reg <= stall_run_reg + 18'd1;
    end
  end

  // Fetch stays open, the first limit write lands, refusals hold, stalls last as timed
  chk_fetch_not_denied: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL3]
    !(CODE_READ || FLASH_WRITE || FLASH_ERASE) |=> !ACCESS_DENIED)
    else $error("access denied without a request");
  chk_upper_read_open: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL4]
    CODE_READ && MEM_ADDR >= boundary |=> CODE_RDATA == $past(FLASH_RDATA))
    else $error("read at or above boundary was altered");
  chk_blocked_read_denied: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL11]
    CODE_READ && blocked |=> ACCESS_DENIED)
    else $error("blocked code read not flagged");
  chk_limit_first_write: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL13]
    SFR_WR && SFR_ADDR == READ_LIMIT_ADDR && !limit_locked_reg |=>
    limit_locked_reg && read_limit_reg == $past(SFR_WDATA))
    else $error("first limit write not taken");
  chk_reserved_no_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL14]
    timing_reg[3:0] > PRESCALE_MAX_VALID |=> !FLASH_PROG_START)
    else $error("program started with reserved prescaler code");
  chk_busy_no_restart: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL12]
    busy_count_reg != 18'd0 |=> !FLASH_PROG_START)
    else $error("program started while busy");
  chk_stall_with_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL12]
    FLASH_PROG_START |-> CORE_STALL)
    else $error("stall not raised with program start");
  chk_stall_length: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [RL12]
    $fell(CORE_STALL) && !$past(SYS_RST) |-> stall_run_reg == stall_want_reg + 18'd1)
    else $error("stall length differs from the timed count");
endmodule

`default_nettype wire

// ---- core/flash_guard_pkg.sv ----
// Constants for the program flash read limit and timing control block.
// Assumes an SFR-style register port driven by the processor core.
package flash_guard_pkg;
  localparam logic [7:0] TIMING_CTRL_ADDR = 8'hb6;
  localparam logic [7:0] READ_LIMIT_ADDR = 8'hb7;
  localparam logic [7:0] TIMING_CTRL_RESET = 8'h8f;
  localparam logic [7:0] READ_LIMIT_RESET = 8'h00;
  localparam int ONESHOT_BIT = 7;
  localparam int READ_ALWAYS_BIT = 6;
  localparam logic [3:0] PRESCALE_DISABLED = 4'hf;
  localparam logic [3:0] PRESCALE_MAX_VALID = 4'ha;
  localparam logic [7:0] BLOCKED_READ_VALUE = 8'h00;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int PRESCALE_BASE_HZ = 50_000;
  // Write and erase durations in microseconds, and cycle counts from them
  localparam int WRITE_TIME_US = 40;
  localparam int ERASE_TIME_US = 10_000;
  localparam int WRITE_CYCLES = (WRITE_TIME_US * (SYS_CLK_HZ / 1_000_000));
  localparam int ERASE_CYCLES = (ERASE_TIME_US * (SYS_CLK_HZ / 1_000_000));
endpackage

// ---- testbench/flash_model.sv ----
// Program flash array model standing on the far side of the read path.
// Assumes the core model holds MEM_ADDR steady while a code read is issued.
`timescale 1ns/10ps
`default_nettype none
module flash_model (
  input wire logic [15:0] addr,
  output logic [7:0] rdata
);
  // Address-derived bytes, zero only where the two address bytes XOR to a5, so a zeroed result rarely matches by chance here
  assign rdata = addr[7:0] ^ addr[15:8] ^ 8'ha5;
endmodule
`default_nettype wire

// ---- testbench/tb_flash_guard.sv ----
// Self-checking bench for the flash read limit and timing block.
// Assumes a 10 MHz clock and a shortened erase count of 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_flash_guard;
  import flash_guard_pkg::*;
  logic clk, rst, wr, crd, fwr, fer, st, ise, den, stall, pv;
  logic [7:0] sa, wd, rd, frd, crdat;
  logic [15:0] pc, ma, rpc;
  int fails, cmp_count, n;
  flash_guard #(.ERASE_CYCLE_COUNT(20)) flash_guard_inst (.SYS_CLK(clk), .SYS_RST(rst),
    .SFR_ADDR(sa), .SFR_WR(wr), .SFR_WDATA(wd), .SFR_RDATA(rd), .FETCH_PC(pc),
    .MEM_ADDR(ma), .CODE_READ(crd), .FLASH_WRITE(fwr), .FLASH_ERASE(fer),
    .FLASH_RDATA(frd), .CODE_RDATA(crdat), .FLASH_PROG_START(st),
    .FLASH_PROG_IS_ERASE(ise), .ACCESS_DENIED(den), .CORE_STALL(stall),
    .RESET_PC(rpc), .PRESCALE_VALID(pv));
  flash_model flash_model_inst (.addr(ma), .rdata(frd));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Each request lets one idle edge pass first, so back-to-back calls never
  // lower and raise a strobe in the same time step
  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk) #1;
    sa = a;
    wd = d;
    wr = w;
    @(posedge clk) #1 wr = 0;
  endtask
  task automatic cread(input logic [15:0] p, input logic [15:0] a);
    @(posedge clk) #1;
    pc = p;
    ma = a;
    crd = 1;
    @(posedge clk) #1 crd = 0;
  endtask
  task automatic prog(input logic [15:0] p, input logic [15:0] a, input logic e);
    @(posedge clk) #1;
    pc = p;
    ma = a;
    fwr = !e;
    fer = e;
    @(posedge clk) #1 fwr = 0;
    fer = 0;
  endtask
  task automatic stall_len(input int exp);
    n = 0;
    while (stall === 1'b1 && n < 1000) begin
      @(posedge clk) #1 n++;
    end
    chk("stall cycles", exp, n[15:0]);
  endtask
  task automatic check_reset_values;
    chk("reset pc", RESET_VECTOR, rpc);
    chk("outputs after reset", 16'h0000, {13'h0, st, den, stall});
    sfr(TIMING_CTRL_ADDR, 8'h00, 0);
    chk("timing reset", 16'h008f, {8'h00, rd});
    chk("prescale valid", 16'h0000, {15'h0, pv});
    sfr(READ_LIMIT_ADDR, 8'h00, 0);
    chk("limit reset", 16'h0000, {8'h00, rd});
  endtask
  task automatic check_open_access;
    cread(16'hff00, 16'h0012);
    chk("open read", 16'h00b7, {7'h0, den, crdat});
    prog(16'h0000, 16'h3000, 0);
    chk("disabled start", 16'h0000, {14'h0, st, den});
  endtask
  task automatic check_limit_lock;
    sfr(READ_LIMIT_ADDR, 8'h20, 1);
    sfr(READ_LIMIT_ADDR, 8'h40, 1);
    sfr(READ_LIMIT_ADDR, 8'h00, 0);
    chk("limit locked", 16'h0020, {8'h00, rd});
  endtask
  task automatic check_partition_reads;
    cread(16'h2000, 16'h1fff);
    chk("blocked read", 16'h0000, {8'h00, crdat});
    chk("read denied", 16'h0001, {15'h0, den});
    cread(16'h1fff, 16'h1f00);
    chk("low read", 16'h00ba, {7'h0, den, crdat});
    // Upper code pointing into the lower partition without a read strobe
    pc = 16'h2000;
    ma = 16'h1f00;
    @(posedge clk) #1;
    chk("fetch only", 16'h00ba, {7'h0, den, crdat});
    cread(16'h2000, 16'h2000);
    chk("edge read", 16'h0085, {7'h0, den, crdat});
  endtask
  task automatic check_timing_store;
    sfr(TIMING_CTRL_ADDR, 8'hf8, 1);
    sfr(TIMING_CTRL_ADDR, 8'h00, 0);
    chk("timing store", 16'h00c8, {8'h00, rd});
    chk("prescale ok", 16'h0001, {15'h0, pv});
  endtask
  task automatic check_program_ops;
    prog(16'h2000, 16'h1000, 0);
    chk("upper write", 16'h0001, {14'h0, st, den});
    prog(16'h0100, 16'h3000, 0);
    chk("write start", 16'h0002, {14'h0, st, ise});
    stall_len(WRITE_CYCLES);
    prog(16'h0100, 16'h3000, 1);
    chk("erase start", 16'h0003, {14'h0, st, ise});
    stall_len(20);
  endtask
  task automatic check_reserved_code;
    sfr(TIMING_CTRL_ADDR, 8'h0b, 1);
    prog(16'h0100, 16'h3000, 0);
    chk("reserved code", 16'h0000, {14'h0, st, pv});
  endtask
  task automatic check_reset_relock;
    @(posedge clk) #1 rst = 1;
    @(posedge clk) #1 rst = 0;
    chk("outputs after second reset", 16'h0000, {13'h0, st, den, stall});
    sfr(TIMING_CTRL_ADDR, 8'h00, 0);
    chk("timing after reset", 16'h008f, {8'h00, rd});
    sfr(READ_LIMIT_ADDR, 8'h00, 0);
    chk("limit after reset", 16'h0000, {8'h00, rd});
    sfr(READ_LIMIT_ADDR, 8'h10, 1);
    sfr(READ_LIMIT_ADDR, 8'h00, 0);
    chk("limit relocked", 16'h0010, {8'h00, rd});
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200_000;
    fails++;
    complete_run;
  end
  initial begin
    rst = 1; wr = 0; crd = 0; fwr = 0; fer = 0; sa = 0; wd = 0; pc = 0; ma = 0;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    check_reset_values;
    check_open_access;
    check_limit_lock;
    check_partition_reads;
    check_timing_store;
    check_program_ops;
    check_reserved_code;
    check_reset_relock;
    complete_run;
  end
endmodule
`default_nettype wire
